// >>> dv/dcdc_ctrl_sva.sv
`timescale 1ns/1ps
// Port checker for the converter controller.
module dcdc_ctrl_sva #(
   parameter bit SAME_POLARITY = 1'b0
) (
   // Clock, reset and register port.
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Converter side.
   input wire logic battery_below_target_i,
   input wire logic monitor_input_high_i,
   input wire logic monitor_input_low_i,
   input wire logic main_switch_drive_o,
   input wire logic feed_forward_drive_o,
   input wire logic [5:0] battery_target_o,
   input wire logic calibrating_o
);
   logic off_reg;
   logic off_next;
   // Shadow of the power-off bit.
   always_comb begin
      off_next = off_reg;
      if (wr_i && addr_i == dcdc_pkg::ADDR_POWERDOWN) begin
         off_next = wdata_i[dcdc_pkg::POWER_OFF_BIT];
      end
   end
   // The converter starts off after reset.
   always_ff @(posedge clk_i) off_reg <= rstn_i ? off_next : 1'b1;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // Overload seen while calibration is idle.
   sequence ovl_s;
      (monitor_input_high_i || monitor_input_low_i) && !calibrating_o;
   endsequence
   // Calibration asked for while the converter is on.
   sequence cal_s;
      wr_i && addr_i == dcdc_pkg::ADDR_SW_DELAY &&
         wdata_i[dcdc_pkg::CAL_BIT] && !off_reg;
   endsequence
   AST_FF_POL: assert property (
      feed_forward_drive_o == (main_switch_drive_o ^ !SAME_POLARITY))
      else $error("feed drive polarity wrong");
   AST_POL_BIT: assert property (
      rd_i && addr_i == dcdc_pkg::ADDR_SW_DELAY |=>
      rdata_o[dcdc_pkg::POLARITY_BIT] == SAME_POLARITY)
      else $error("polarity bit wrong");
   AST_OFF_RISE: assert property (
      $rose(main_switch_drive_o) |-> !$past(off_reg))
      else $error("drive while powered off");
   AST_ABOVE_RISE: assert property (
      (!battery_below_target_i) [*4] |-> !$rose(main_switch_drive_o))
      else $error("pulse while above target");
   AST_OVL_CUT: assert property (
      ovl_s ##0 main_switch_drive_o |-> ##[1:8] !main_switch_drive_o)
      else $error("overload did not end pulse");
   AST_MIN_OFF: assert property (
      $fell(main_switch_drive_o) |-> (!main_switch_drive_o) [*8])
      else $error("off time too short");
   AST_CAL_START: assert property (
      cal_s |-> ##[1:2] calibrating_o)
      else $error("calibration did not start");
   AST_TGT_READ: assert property (
      rd_i && addr_i == dcdc_pkg::ADDR_LINE_LEVEL |=>
      rdata_o == {2'h0, $past(battery_target_o)})
      else $error("target readback wrong");
endmodule
bind battery_dcdc_pwm_controller dcdc_ctrl_sva #(
   .SAME_POLARITY(SAME_POLARITY)
) dcdc_ctrl_sva_inst (
   .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .battery_below_target_i(battery_below_target_i),
   .monitor_input_high_i(monitor_input_high_i),
   .monitor_input_low_i(monitor_input_low_i),
   .main_switch_drive_o(main_switch_drive_o),
   .feed_forward_drive_o(feed_forward_drive_o),
   .battery_target_o(battery_target_o), .calibrating_o(calibrating_o)
);

// >>> dv/dcdc_plant.sv
`timescale 1ns/1ps
// Switch, inductor and output comparator behind the drive pins.
module dcdc_plant (
   // Clock, drive and commanded overload.
   input wire logic clk_i,
   input wire logic drive_i,
   input wire logic [1:0] ovl_i,
   // Sense and monitor lines.
   output logic below_o,
   output logic mon_hi_o,
   output logic mon_lo_o
);
   logic [11:0] lvl = 12'h000;
   // Output charges fast while switched and bleeds slowly otherwise, so
   // the comparator crosses its threshold within a few periods.
   always @(posedge clk_i) begin
      if (drive_i && lvl < 12'hffc) begin
         lvl <= lvl + 12'h004;
      end else if (!drive_i && lvl != 12'h000) begin
         lvl <= lvl - 12'h001;
      end
   end
   // Comparator and the two overload monitors.
   assign below_o = lvl < 12'h800;
   assign mon_hi_o = ovl_i[0];
   assign mon_lo_o = ovl_i[1];
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
// Register and switching checks for the converter controller.
module testbench;
   logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, want;
   logic [5:0] cm = 6'h00, oc = 6'h00, lp = 6'h00, tgt, ov, lo, hi;
   logic [1:0] ovl = 2'h0;
   logic below, mon_hi, mon_lo, main_o, ff_o, cal_o;
   logic [31:0] seed = 32'h7070d8d9;
   logic [7:0] exp_q[$];
   int n_fail = 0, compares = 0, rises = 0;
   battery_dcdc_pwm_controller battery_dcdc_pwm_controller_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .battery_below_target_i(below), .monitor_input_high_i(mon_hi),
      .monitor_input_low_i(mon_lo), .common_mode_level_i(cm),
      .open_circuit_level_i(oc), .loop_level_i(lp),
      .main_switch_drive_o(main_o), .feed_forward_drive_o(ff_o),
      .battery_target_o(tgt), .calibrating_o(cal_o));
   dcdc_plant dcdc_plant_inst (.clk_i(clk_i), .drive_i(main_o), .ovl_i(ovl),
      .below_o(below), .mon_hi_o(mon_hi), .mon_lo_o(mon_lo));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Counts drive pulses.
   always @(posedge main_o) rises++;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Expected target for a feed mode (bit 1 current feed, bit 0 tracking).
   function automatic logic [5:0] target(input logic [1:0] m);
      logic [5:0] s;
      s = (m[1] ? lp : oc) + cm + ov;
      if (m == 2'h2 && s < lo) s = lo;
      if (s > hi) s = hi;
      return s;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      addr_i <= a;
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
   endtask
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wait_rises(input int n);
      int t;
      t = rises + n;
      for (int i = 0; i < 3000 && rises < t; i++) idle(1);
      if (rises < t) begin
         n_fail++;
         finish_test();
      end
   endtask
   // Pairs each returned read word with the oldest expectation.
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      if (rd_d) begin
         check(rdata_o, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      // Reset values, unmapped space and read-only places.
      rd(8'h0e, 8'h10);
      rd(8'h5c, 8'hff);
      wr(8'h33, 8'hff);
      wr(8'h5e, 8'h5a);
      wr(8'h5d, 8'ha2);
      rd(8'h33, 8'h00);
      rd(8'h5e, 8'h00);
      rd(8'h5d, 8'h02);
      seed = xs(seed);
      wr(8'h5c, seed[7:0]);
      rd(8'h5c, seed[7:0]);
      // No room for a pulse when the off time fills the period.
      wr(8'h5c, 8'h20);
      wr(8'h5d, 8'h1f);
      wr(8'h0e, 8'h00);
      idle(500);
      check(8'(rises), 8'h00);
      // Full pulses of period less off time while below target.
      wr(8'h5d, 8'h02);
      wait_rises(3);
      check({6'h00, main_o, ff_o}, 8'h02);
      rd(8'h5e, 8'h1a);
      // Each monitor line alone cancels whole pulses.
      for (int i = 1; i < 3; i++) begin
         ovl <= 2'(i);
         idle(450);
         rd(8'h5e, 8'h00);
         ovl <= 2'h0;
         wait_rises(2);
      end
      // Calibration runs once the converter is on.
      wr(8'h5d, 8'h82);
      rd(8'h5d, 8'h82);
      for (int i = 0; i < 400 && cal_o !== 1'b0; i++) idle(1);
      check({7'h0, cal_o}, 8'h00);
      rd(8'h5d, 8'h02);
      // Regulation target in every feed and tracking mode.
      for (int m = 0; m < 4; m++) begin
         seed = xs(seed);
         cm <= {2'h0, seed[3:0]};
         oc <= {2'h0, seed[7:4]};
         lp <= {2'h0, seed[11:8]};
         lo = {1'b0, seed[16:12]};
         hi = {1'b1, seed[21:17]};
         ov = {2'h0, seed[25:22] > seed[29:26] ? seed[25:22] : seed[29:26]};
         wr(8'h42, {4'h0, seed[25:22]});
         wr(8'h60, {4'h0, seed[29:26]});
         wr(8'h61, {6'h0, 2'(m)});
         wr(8'h4b, {2'h0, lo});
         wr(8'h4a, {2'h0, hi});
         idle(4);
         check({2'h0, tgt}, {2'h0, target(2'(m))});
         rd(8'h62, {2'h0, target(2'(m))});
      end
      // Powered off again, no further pulses.
      wr(8'h0e, 8'h10);
      rd(8'h0e, 8'h10);
      idle(2);
      want = 8'(rises);
      idle(300);
      check(8'(rises), want);
      finish_test();
   end
endmodule

// >>> hdl/battery_dcdc_pwm_controller.sv
`timescale 1ns/1ps
module battery_dcdc_pwm_controller #(
   parameter bit SAME_POLARITY = 1'b0
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Converter sense and monitor inputs.
   input wire logic battery_below_target_i,
   input wire logic monitor_input_high_i,
   input wire logic monitor_input_low_i,
   // Line levels in 1.5 V steps from the line driver.
   input wire logic [5:0] common_mode_level_i,
   input wire logic [5:0] open_circuit_level_i,
   input wire logic [5:0] loop_level_i,
   // Switch drives and status.
   output logic main_switch_drive_o,
   output logic feed_forward_drive_o,
   output logic [5:0] battery_target_o,
   output logic calibrating_o
);
   logic [7:0] powerdown_reg, powerdown_next;
   logic [7:0] overhead_reg, overhead_next;
   logic [5:0] high_bat_reg, high_bat_next;
   logic [5:0] low_bat_reg, low_bat_next;
   logic [7:0] period_reg, period_next;
   logic [4:0] off_time_reg, off_time_next;
   logic [3:0] min_ovh_reg, min_ovh_next;
   logic [1:0] feed_reg, feed_next;
   logic [7:0] width_reg, width_next;
   logic [7:0] rdata_reg, rdata_next;
   dcdc_pkg::pwm_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [7:0] on_cnt_reg, on_cnt_next;
   logic drive_reg, drive_next;
   logic ff_reg, ff_next;
   logic [15:0] cal_reg, cal_next;
   logic [5:0] target_reg, target_next;
   logic busy_reg, busy_next;
   logic tick;
   logic overload;
   logic conv_on;
   logic [7:0] on_limit;

   // Saturating sum of levels in 1.5 V steps, kept within 6 bits.
   function automatic logic [5:0] sat_add(input logic [6:0] a,
                                          input logic [6:0] b);
      logic [7:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > 8'd63) ? 6'h3f : s[5:0];
   endfunction

   // Minimum off time in converter ticks: the field plus the fixed count.
   function automatic logic [7:0] min_off_ticks(input logic [4:0] field);
      min_off_ticks = {3'b000, field} + dcdc_pkg::OFF_TIME_ADD;
   endfunction

   // Converter tick at 16.384 MHz made from the 100 MHz clock.
   dcdc_tick_gen u_tick (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_o(tick)
   );

   assign conv_on = !powerdown_reg[dcdc_pkg::POWER_OFF_BIT];
   // Overload is ignored while calibration nulls the monitor inputs;
   // otherwise the nulling itself would cut the first pulses short.
   assign overload = (monitor_input_high_i | monitor_input_low_i)
                     && (cal_reg == 16'h0000);
   assign on_limit = (period_reg > min_off_ticks(off_time_reg))
                     ? period_reg - min_off_ticks(off_time_reg) : 8'h00;

   // Register writes and read data. Unmapped addresses read as zero and
   // ignore writes; the pulse width and line level places are read-only.
   // Read data stand for one cycle only, then fall back to zero.
   always_comb begin
      powerdown_next = powerdown_reg;
      overhead_next = overhead_reg;
      high_bat_next = high_bat_reg;
      low_bat_next = low_bat_reg;
      period_next = period_reg;
      off_time_next = off_time_reg;
      min_ovh_next = min_ovh_reg;
      feed_next = feed_reg;
      rdata_next = 8'h00;
      if (wr_i) begin
         if (addr_i == dcdc_pkg::ADDR_POWERDOWN) begin
            powerdown_next = wdata_i;
         end else if (addr_i == dcdc_pkg::ADDR_OVERHEAD) begin
            overhead_next = wdata_i;
         end else if (addr_i == dcdc_pkg::ADDR_HIGH_BAT) begin
            high_bat_next = wdata_i[5:0];
         end else if (addr_i == dcdc_pkg::ADDR_LOW_BAT) begin
            low_bat_next = wdata_i[5:0];
         end else if (addr_i == dcdc_pkg::ADDR_PERIOD) begin
            period_next = wdata_i;
         end else if (addr_i == dcdc_pkg::ADDR_SW_DELAY) begin
            off_time_next = wdata_i[4:0];
         end else if (addr_i == dcdc_pkg::ADDR_MIN_OVERHEAD) begin
            min_ovh_next = wdata_i[3:0];
         end else if (addr_i == dcdc_pkg::ADDR_FEED_CTRL) begin
            feed_next = wdata_i[1:0];
         end
      end
      if (rd_i) begin
         if (addr_i == dcdc_pkg::ADDR_POWERDOWN) begin
            rdata_next = powerdown_reg;
         end else if (addr_i == dcdc_pkg::ADDR_OVERHEAD) begin
            rdata_next = overhead_reg;
         end else if (addr_i == dcdc_pkg::ADDR_HIGH_BAT) begin
            rdata_next = {2'b00, high_bat_reg};
         end else if (addr_i == dcdc_pkg::ADDR_LOW_BAT) begin
            rdata_next = {2'b00, low_bat_reg};
         end else if (addr_i == dcdc_pkg::ADDR_PERIOD) begin
            rdata_next = period_reg;
         end else if (addr_i == dcdc_pkg::ADDR_SW_DELAY) begin
            rdata_next = {(cal_reg != 16'h0000), 1'b0, SAME_POLARITY,
                          off_time_reg};
         end else if (addr_i == dcdc_pkg::ADDR_PULSE_WIDTH) begin
            rdata_next = width_reg;
         end else if (addr_i == dcdc_pkg::ADDR_MIN_OVERHEAD) begin
            rdata_next = {4'h0, min_ovh_reg};
         end else if (addr_i == dcdc_pkg::ADDR_FEED_CTRL) begin
            rdata_next = {6'h00, feed_reg};
         end else if (addr_i == dcdc_pkg::ADDR_LINE_LEVEL) begin
            rdata_next = {2'b00, target_reg};
         end
      end
   end

   // Calibration runs a fixed time after a write of the calibration bit.
   // A request while the converter is off is dropped, since the monitor
   // inputs carry nothing to null then.
   always_comb begin
      cal_next = (cal_reg != 16'h0000) ? cal_reg - 16'h0001 : cal_reg;
      if (wr_i && addr_i == dcdc_pkg::ADDR_SW_DELAY
          && wdata_i[dcdc_pkg::CAL_BIT] && conv_on) begin
         cal_next = 16'(dcdc_pkg::CAL_CYCLES);
      end
      // The busy flag follows the counter so the output is registered.
      busy_next = (cal_next != 16'h0000);
   end

   // Regulation target magnitude in 1.5 V steps.
   // Each sum saturates at the top code, and the high battery setting
   // caps the result in every feed mode.
   always_comb begin
      logic [5:0] ovh;
      logic [5:0] base;
      base = 6'h00;
      // overhead, larger of direct and minimum
      ovh = (overhead_reg[5:0] > {2'b00, min_ovh_reg})
            ? overhead_reg[5:0] : {2'b00, min_ovh_reg};
      if (feed_reg[dcdc_pkg::CC_MODE_BIT]) begin
         base = sat_add({1'b0, loop_level_i},
                        {1'b0, common_mode_level_i});
         target_next = sat_add({1'b0, base}, {1'b0, ovh});
         if (!feed_reg[dcdc_pkg::TRACK_BIT] && target_next < low_bat_reg) begin
            target_next = low_bat_reg;
         end
      end else begin
         base = sat_add({1'b0, common_mode_level_i},
                        {1'b0, open_circuit_level_i});
         target_next = sat_add({1'b0, base}, {1'b0, ovh});
      end
      if (target_next > high_bat_reg) begin
         target_next = high_bat_reg;
      end
   end

   // PWM state machine, advanced on each converter tick. A period lasts
   // period_reg ticks; the tick that ends one period starts the next.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      on_cnt_next = on_cnt_reg;
      drive_next = drive_reg;
      width_next = width_reg;
      if (!conv_on) begin
         state_next = dcdc_pkg::ST_OFF;
         drive_next = 1'b0;
         cnt_next = 8'h00;
         on_cnt_next = 8'h00;
      end else if (tick) begin
         cnt_next = cnt_reg + 8'h01;
         case (state_reg)
            dcdc_pkg::ST_ON: begin
               if (drive_reg) begin
                  on_cnt_next = on_cnt_reg + 8'h01;
               end
               if (overload || on_cnt_next >= on_limit) begin
                  drive_next = 1'b0;
                  state_next = dcdc_pkg::ST_BLANK;
               end
            end
            default: begin
               // Off after power-on, or blanked until the period ends.
               drive_next = 1'b0;
            end
         endcase
         if (state_reg == dcdc_pkg::ST_OFF || cnt_next >= period_reg) begin
            if (state_reg != dcdc_pkg::ST_OFF) begin
               width_next = on_cnt_next;
            end
            state_next = dcdc_pkg::ST_ON;
            cnt_next = 8'h00;
            on_cnt_next = 8'h00;
            drive_next = battery_below_target_i && (on_limit != 8'h00)
                         && !overload;
         end
      end
      ff_next = SAME_POLARITY ? drive_next : !drive_next;
   end

   // State registers. Reset leaves the converter off and both drives
   // at their idle levels.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         powerdown_reg <= dcdc_pkg::POWERDOWN_RST;
         overhead_reg <= dcdc_pkg::OVERHEAD_RST;
         high_bat_reg <= dcdc_pkg::HIGH_BAT_RST[5:0];
         low_bat_reg <= dcdc_pkg::LOW_BAT_RST[5:0];
         period_reg <= dcdc_pkg::PERIOD_RST;
         off_time_reg <= dcdc_pkg::OFF_TIME_RST;
         min_ovh_reg <= dcdc_pkg::MIN_OVERHEAD_RST;
         feed_reg <= dcdc_pkg::FEED_CTRL_RST;
         width_reg <= 8'h00;
         rdata_reg <= 8'h00;
         state_reg <= dcdc_pkg::ST_OFF;
         cnt_reg <= 8'h00;
         on_cnt_reg <= 8'h00;
         drive_reg <= 1'b0;
         ff_reg <= !SAME_POLARITY;
         cal_reg <= 16'h0000;
         target_reg <= 6'h00;
         busy_reg <= 1'b0;
      end else begin
         powerdown_reg <= powerdown_next;
         overhead_reg <= overhead_next;
         high_bat_reg <= high_bat_next;
         low_bat_reg <= low_bat_next;
         period_reg <= period_next;
         off_time_reg <= off_time_next;
         min_ovh_reg <= min_ovh_next;
         feed_reg <= feed_next;
         width_reg <= width_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         on_cnt_reg <= on_cnt_next;
         drive_reg <= drive_next;
         ff_reg <= ff_next;
         cal_reg <= cal_next;
         target_reg <= target_next;
         busy_reg <= busy_next;
      end
   end

   // Outputs straight from flip-flops.
   // The calibration flag has its own register so it cannot glitch.
   assign rdata_o = rdata_reg;
   assign main_switch_drive_o = drive_reg;
   assign feed_forward_drive_o = ff_reg;
   assign battery_target_o = target_reg;
   assign calibrating_o = busy_reg;
endmodule

// >>> hdl/dcdc_pkg.sv
package dcdc_pkg;
   // Register byte addresses on the plain register port.
   localparam logic [7:0] ADDR_POWERDOWN = 8'h0e;
   localparam logic [7:0] ADDR_OVERHEAD = 8'h42;
   localparam logic [7:0] ADDR_HIGH_BAT = 8'h4a;
   localparam logic [7:0] ADDR_LOW_BAT = 8'h4b;
   localparam logic [7:0] ADDR_PERIOD = 8'h5c;
   localparam logic [7:0] ADDR_SW_DELAY = 8'h5d;
   localparam logic [7:0] ADDR_PULSE_WIDTH = 8'h5e;
   localparam logic [7:0] ADDR_MIN_OVERHEAD = 8'h60;
   localparam logic [7:0] ADDR_FEED_CTRL = 8'h61;
   localparam logic [7:0] ADDR_LINE_LEVEL = 8'h62;

   // Field positions.
   localparam int POWER_OFF_BIT = 4;
   localparam int POLARITY_BIT = 5;
   localparam int CAL_BIT = 7;
   localparam int TRACK_BIT = 0;
   localparam int CC_MODE_BIT = 1;
   localparam int STEP_W = 6;

   // Reset values.
   localparam logic [7:0] POWERDOWN_RST = 8'h10;
   localparam logic [7:0] OVERHEAD_RST = 8'h00;
   localparam logic [7:0] HIGH_BAT_RST = 8'h00;
   localparam logic [7:0] LOW_BAT_RST = 8'h00;
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [4:0] OFF_TIME_RST = 5'h00;
   localparam logic [3:0] MIN_OVERHEAD_RST = 4'h0;
   localparam logic [1:0] FEED_CTRL_RST = 2'h0;

   // Timing: minimum off time adds a fixed count, calibration length.
   localparam logic [7:0] OFF_TIME_ADD = 8'h04;
   localparam real CAL_TIME_NS = 2000.0;
   localparam real CLK_PERIOD_NS = 10.0;
   localparam int CAL_CYCLES = int'(CAL_TIME_NS / CLK_PERIOD_NS);

   // Divider producing the 16.384 MHz converter tick from 100 MHz.
   localparam logic [15:0] TICK_INC = 16'd10737;

   typedef enum logic [1:0] {ST_OFF, ST_ON, ST_BLANK} pwm_state_t;
endpackage

// >>> hdl/dcdc_tick_gen.sv
`timescale 1ns/1ps
// Fractional divider that makes a one-cycle enable at 16.384 MHz.
module dcdc_tick_gen (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rstn_i,
   // Tick output.
   output logic tick_o
);
   logic [15:0] acc_reg;
   logic [15:0] acc_next;
   logic tick_reg;
   logic tick_next;
   logic [16:0] sum;

   // Phase accumulator; the carry marks a tick.
   always_comb begin
      sum = {1'b0, acc_reg} + {1'b0, dcdc_pkg::TICK_INC};
      acc_next = sum[15:0];
      tick_next = sum[16];
   end

   // Accumulator state.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         acc_reg <= 16'h0000;
         tick_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_o = tick_reg;
endmodule
